/* tb/agent_core_model.sv */
// Purpose: behavioural agent core and flush engine facing the register bank
// Assumes: same sys_clk, flush length chosen by the bench
// Notes: quiesce is reached three cycles after the request level
module agent_core_model
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// from the bank; flush_delay from the bench
	input wire logic flush_start,
	input wire logic quiesce_request,
	input wire logic [7:0] flush_delay,
	// to the bank
	output logic flush_complete,
	output logic quiesce_reached
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q;
	logic busy_q;
	logic [1:0] qdly_q;
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			qdly_q <= 2'h0;
			flush_complete <= 1'b0;
			quiesce_reached <= 1'b0;
		end
		else
		begin
			flush_complete <= 1'b0;
			qdly_q <= {qdly_q[0], quiesce_request};
			quiesce_reached <= qdly_q[1];
			if (flush_start)
			begin
				busy_q <= 1'b1;
				cnt_q <= flush_delay;
			end
			else if (busy_q && cnt_q == 8'h00)
			begin
				busy_q <= 1'b0;
				flush_complete <= 1'b1;
			end
			else if (busy_q)
				cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

/* tb/request_agent_ctrl_status_tb_top.sv */
// Purpose: self-checking bench for the requesting agent register bank
// Assumes: 50 ns sys_clk, registered read data one cycle after the strobe
// Notes: flush budget is 5 * 1024 ns, i.e. 102 cycles
module request_agent_ctrl_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [8:0] CNT = 9'h005;
	localparam logic [2:0] EXP = 3'h2;
	localparam logic [11:0] ELOG = 12'h5a0;
	typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] wd; logic [31:0] exp;} row_s;
	logic sys_clk = 1'b0, resetn = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
	logic [7:0] cfg_addr = 8'h00, snoop_req_id = 8'h00, flush_delay = 8'h0a;
	logic [3:0] cfg_byte_en = 4'hf;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd;
	logic cfg_rd_valid, request_allowed, quiesce_request, quiesce_reached, flush_start;
	logic flush_complete, flush_overdue, snoop_req_valid = 1'b0, snoop_req_ready, snoop_rsp_valid;
	logic [7:0] snoop_rsp_id;
	logic [7:0] rsp_q[$];
	int error_cnt = 0, checked = 0, cycles = 0, starts = 0;
	row_s rows[6] = '{
		'{8'h04, 4'hf, 32'hffff_bff7, 32'h0000_3ff7},
		'{8'h04, 4'hf, 32'h0000_0000, 32'h0000_0000},
		'{8'h04, 4'h1, 32'hffff_fff7, 32'h0000_00f7},
		'{8'h00, 4'hf, 32'hffff_ffff, {1'b0, EXP, CNT, 19'h0}},
		'{8'h08, 4'hf, 32'hffff_ffff, {20'h0, ELOG}},
		'{8'h0c, 4'hf, 32'hffff_ffff, 32'h0000_0000}};
	request_agent_ctrl_status #(.FLUSH_TIME_COUNT(CNT), .FLUSH_TIME_EXP(EXP), .ERR_LOG_OFFSET(ELOG)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
		.cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rd_valid(cfg_rd_valid), .request_allowed(request_allowed), .quiesce_request(quiesce_request),
		.quiesce_reached(quiesce_reached), .flush_start(flush_start), .flush_complete(flush_complete),
		.flush_overdue(flush_overdue), .snoop_req_valid(snoop_req_valid), .snoop_req_id(snoop_req_id),
		.snoop_req_ready(snoop_req_ready), .snoop_rsp_valid(snoop_rsp_valid), .snoop_rsp_id(snoop_rsp_id));
	agent_core_model partner (.sys_clk(sys_clk), .resetn(resetn), .flush_start(flush_start),
		.quiesce_request(quiesce_request), .flush_delay(flush_delay), .flush_complete(flush_complete),
		.quiesce_reached(quiesce_reached));
	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (snoop_rsp_valid === 1'b1)
			rsp_q.push_back(snoop_rsp_id);
		if (flush_start === 1'b1)
			starts++;
		if (cycles == 3000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		@(posedge sys_clk);
		cfg_wr_en <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_byte_en <= be;
		@(posedge sys_clk);
		cfg_wr_en <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge sys_clk);
		cfg_rd_en <= 1'b1;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd_en <= 1'b0;
		#1;
		while (cfg_rd_valid !== 1'b1 && n < 3)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		rd = cfg_rdata;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rdw(8'h04);
		chk("control after reset", 32'h0, rd);
		chk("enable outputs after reset", 32'h0, {request_allowed, snoop_req_ready});
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].wd, rows[i].be);
			rdw(rows[i].a);
			chk("table row", rows[i].exp, rd);
		end
		// snoop enable with the agent enable, as software must
		wr(8'h04, 32'h0000_0003);
		rdw(8'h04);
		chk("agent and snoop enable", 32'h3, {request_allowed, snoop_req_ready});
		rsp_q.delete();
		@(posedge sys_clk);
		snoop_req_valid <= 1'b1;
		snoop_req_id <= 8'h11;
		@(posedge sys_clk);
		snoop_req_id <= 8'h22;
		@(posedge sys_clk);
		snoop_req_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("snoop replies", 32'h1122, (rsp_q.size() == 2) ? {rsp_q[0], rsp_q[1]} : 16'hxxxx);
		wr(8'h04, 32'h0);
		rsp_q.delete();
		@(posedge sys_clk);
		snoop_req_valid <= 1'b1;
		@(posedge sys_clk);
		snoop_req_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("snoop refused when off", 32'h0, rsp_q.size());
		// quiesce request, accelerators assumed already idle
		wr(8'h04, 32'h0000_0008);
		repeat (6) @(posedge sys_clk);
		rdw(8'h00);
		chk("quiesce acknowledged", 32'h8, rd & 32'h8);
		wr(8'h04, 32'h0);
		repeat (6) @(posedge sys_clk);
		rdw(8'h00);
		chk("quiesce released", 32'h0, rd & 32'h8);
		// prompt flush
		starts = 0;
		wr(8'h04, 32'h0000_4000);
		repeat (30) @(posedge sys_clk);
		rdw(8'h00);
		chk("flush done", {1'b1, EXP, CNT, 19'h0}, rd);
		chk("one start pulse, not overdue", 32'h1, {flush_overdue, starts[3:0]});
		wr(8'h04, 32'h0);
		rdw(8'h00);
		chk("done cleared", 32'h0, rd[31]);
		// slow flush runs past its budget
		flush_delay <= 8'hc8;
		wr(8'h04, 32'h0000_4000);
		repeat (110) @(posedge sys_clk);
		rdw(8'h00);
		chk("overdue and not done", 32'h1, {rd[31], flush_overdue});
		wr(8'h04, 32'h0);
		repeat (120) @(posedge sys_clk);
		rdw(8'h00);
		chk("late completion ignored", 32'h0, {rd[31], flush_overdue});
		// reset in mid-run clears control
		wr(8'h04, 32'h0000_0ff3);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rdw(8'h04);
		chk("control after second reset", 32'h0, rd);
		wrap_up();
	end
endmodule

/* verilog/flush_deadline_timer.sv */
// Purpose: counts cycles of a running cache flush against its reported budget
// Assumes: run is a same-clock level, high from flush start until completion
// Notes: overdue is a level that holds until run falls
module flush_deadline_timer #(
	parameter longint BUDGET_CYCLES = 1,
	parameter int CNT_W = 48
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// control
	input wire logic run,
	// status
	output logic overdue
);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic overdue_q;
	logic overdue_d;

	always_comb
	begin
		count_d = count_q;
		overdue_d = overdue_q;
		if (!run)
		begin
			count_d = '0;
			overdue_d = 1'b0;
		end
		else if (count_q >= BUDGET_CYCLES[CNT_W-1:0])
			overdue_d = 1'b1;
		else
			count_d = count_q + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_q <= '0;
			overdue_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			overdue_q <= overdue_d;
		end
	end

	assign overdue = overdue_q;

endmodule

/* verilog/request_agent_ctrl_status.sv */
// Purpose: control and capability status registers of a coherent requesting agent
// Assumes: configuration accesses and agent core signals share sys_clk
// Notes: no function-level reset input exists, so only resetn clears state
// Notes on behaviour
// - flush time count is a read-only nine-bit value, 0 to 511.
// - flush time count is valid from reset, not tied to discovery ready.
// - flush exponent in bits 30:28, multiplier is 32 to that power ns.
// - flush exponent is valid from reset, like the count.
// - bit 31 reads 1 once the cache flush has completed.
// - done must be set within count times multiplier after flush request rises.
// - done clears when the flush request bit falls.
// - conventional reset zeroes done and all control bits; function reset does not.
// - offset 08h word carries the error log offset, other bits zero.
// - agent enable bit 0 gates issuing requests to home agents.
// - quiesce request bit 3 asks the agent to reach a quiesced state.
// - quiesce acknowledge changes only after the request bit changed.
// - flush request bit 14 starts write-back and invalidate; snoops still serviced.
module request_agent_ctrl_status #(
	parameter logic [8:0] FLUSH_TIME_COUNT = 9'h010,
	parameter logic [2:0] FLUSH_TIME_EXP = 3'h2,
	parameter logic [11:0] ERR_LOG_OFFSET = 12'h000,
	parameter int SNOOP_ID_W = 8
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// configuration access
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_valid,
	// agent core control
	output logic request_allowed,
	output logic quiesce_request,
	input wire logic quiesce_reached,
	// cache flush engine
	output logic flush_start,
	input wire logic flush_complete,
	output logic flush_overdue,
	// snoop channel
	input wire logic snoop_req_valid,
	input wire logic [SNOOP_ID_W-1:0] snoop_req_id,
	output logic snoop_req_ready,
	output logic snoop_rsp_valid,
	output logic [SNOOP_ID_W-1:0] snoop_rsp_id
);

	// budget rounded down: longest time allowed
	localparam longint FLUSH_BUDGET_NS =
		longint'(FLUSH_TIME_COUNT) * (longint'(1) << (request_agent_pkg::EXP_SHIFT * int'(FLUSH_TIME_EXP)));
	localparam longint FLUSH_BUDGET_RAW = FLUSH_BUDGET_NS / request_agent_pkg::CLK_PERIOD_NS;
	localparam longint FLUSH_BUDGET_CYCLES = (FLUSH_BUDGET_RAW < 1) ? 1 : FLUSH_BUDGET_RAW;

	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic rd_valid_q;
	logic rd_valid_d;
	request_agent_pkg::flush_state_e flush_q;
	request_agent_pkg::flush_state_e flush_d;
	logic start_q;
	logic start_d;
	logic qack_q;
	logic qack_d;
	logic rsp_valid_q;
	logic rsp_valid_d;
	logic [SNOOP_ID_W-1:0] rsp_id_q;
	logic [SNOOP_ID_W-1:0] rsp_id_d;
	logic flush_bit;
	logic snoop_en;

	// per-byte merge of a write under the writable mask
	function automatic logic [31:0] merge_write(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & request_agent_pkg::CONTROL_WMASK;
		merge_write = (old_v & ~m) | (new_v & m);
	endfunction

	assign flush_bit = ctrl_q[request_agent_pkg::FLUSH_REQ_BIT];
	assign snoop_en = ctrl_q[request_agent_pkg::SNOOP_ENABLE_BIT];

	// control register
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (cfg_wr_en && cfg_addr == request_agent_pkg::AGENT_CONTROL_OFS)
			ctrl_d = merge_write(ctrl_q, cfg_wdata, cfg_byte_en);
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_q <= request_agent_pkg::CONTROL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	// flush sequencing
	always_comb
	begin
		flush_d = flush_q;
		start_d = 1'b0;
		case (flush_q)
			request_agent_pkg::FLUSH_IDLE:
			begin
				if (flush_bit)
				begin
					flush_d = request_agent_pkg::FLUSH_BUSY;
					start_d = 1'b1;
				end
			end
			request_agent_pkg::FLUSH_BUSY:
			begin
				// completion sets done; set wins over a falling request
				if (flush_complete)
					flush_d = request_agent_pkg::FLUSH_DONE;
				else if (!flush_bit)
					flush_d = request_agent_pkg::FLUSH_IDLE;
			end
			request_agent_pkg::FLUSH_DONE:
			begin
				if (!flush_bit)
					flush_d = request_agent_pkg::FLUSH_IDLE;
			end
			default:
				flush_d = request_agent_pkg::FLUSH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flush_q <= request_agent_pkg::FLUSH_IDLE;
			start_q <= 1'b0;
		end
		else
		begin
			flush_q <= flush_d;
			start_q <= start_d;
		end
	end

	flush_deadline_timer #(
		.BUDGET_CYCLES(FLUSH_BUDGET_CYCLES),
		.CNT_W(48)
	) u_deadline (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(flush_q == request_agent_pkg::FLUSH_BUSY),
		.overdue(flush_overdue)
	);

	// quiesce acknowledge only moves toward the request value
	always_comb
	begin
		qack_d = qack_q;
		if (ctrl_q[request_agent_pkg::QUIESCE_REQ_BIT] && quiesce_reached)
			qack_d = 1'b1;
		else if (!ctrl_q[request_agent_pkg::QUIESCE_REQ_BIT])
			qack_d = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			qack_q <= 1'b0;
		else
			qack_q <= qack_d;
	end

	// snoop answers continue during a flush; one-cycle turnaround
	always_comb
	begin
		rsp_valid_d = snoop_req_valid && snoop_en;
		rsp_id_d = rsp_valid_d ? snoop_req_id : rsp_id_q;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rsp_valid_q <= 1'b0;
			rsp_id_q <= '0;
		end
		else
		begin
			rsp_valid_q <= rsp_valid_d;
			rsp_id_q <= rsp_id_d;
		end
	end

	// read path; unmapped offsets read zero
	always_comb
	begin
		rdata_d = rdata_q;
		rd_valid_d = cfg_rd_en;
		if (cfg_rd_en)
		begin
			rdata_d = 32'h0000_0000;
			if (cfg_addr == request_agent_pkg::CAP_STATUS_OFS)
			begin
				rdata_d[request_agent_pkg::FLUSH_COUNT_MSB:request_agent_pkg::FLUSH_COUNT_LSB] = FLUSH_TIME_COUNT;
				rdata_d[request_agent_pkg::FLUSH_EXP_MSB:request_agent_pkg::FLUSH_EXP_LSB] = FLUSH_TIME_EXP;
				rdata_d[request_agent_pkg::FLUSH_DONE_BIT] = (flush_q == request_agent_pkg::FLUSH_DONE);
				rdata_d[request_agent_pkg::QUIESCE_REQ_BIT] = qack_q;
			end
			else if (cfg_addr == request_agent_pkg::AGENT_CONTROL_OFS)
				rdata_d = ctrl_q;
			else if (cfg_addr == request_agent_pkg::ERROR_LOG_POINTER_OFS)
				rdata_d[request_agent_pkg::ERR_LOG_W-1:0] = ERR_LOG_OFFSET;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= 32'h0000_0000;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign request_allowed = ctrl_q[request_agent_pkg::AGENT_ENABLE_BIT];
	assign quiesce_request = ctrl_q[request_agent_pkg::QUIESCE_REQ_BIT];
	assign flush_start = start_q;
	assign snoop_req_ready = snoop_en;
	assign snoop_rsp_valid = rsp_valid_q;
	assign snoop_rsp_id = rsp_id_q;
	assign cfg_rdata = rdata_q;
	assign cfg_rd_valid = rd_valid_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	chk_cap_count_read: assert property (
		cfg_rd_en && cfg_addr == request_agent_pkg::CAP_STATUS_OFS |=> cfg_rd_valid && cfg_rdata[27:19] == FLUSH_TIME_COUNT)
		else $error("flush time count misreported");
	chk_cap_exp_read: assert property (
		cfg_rd_en && cfg_addr == request_agent_pkg::CAP_STATUS_OFS |=> cfg_rdata[30:28] == FLUSH_TIME_EXP)
		else $error("flush exponent misreported");
	chk_done_reported: assert property (
		flush_q == request_agent_pkg::FLUSH_BUSY && flush_complete |=> flush_q == request_agent_pkg::FLUSH_DONE)
		else $error("flush done not reported");
	chk_done_clears: assert property (
		$fell(flush_bit) |=> ##1 flush_q != request_agent_pkg::FLUSH_DONE)
		else $error("flush done not cleared");
	chk_flush_start: assert property (
		$rose(flush_bit) && flush_q == request_agent_pkg::FLUSH_IDLE |=> flush_start ##1 !flush_start)
		else $error("flush start not pulsed");
	chk_snoop_answer: assert property (
		snoop_req_valid && snoop_req_ready |=> snoop_rsp_valid && snoop_rsp_id == $past(snoop_req_id))
		else $error("snoop not answered");
	chk_snoop_gated: assert property (
		!snoop_en |=> !snoop_rsp_valid)
		else $error("snoop answered while disabled");
	chk_quiesce_follows: assert property (
		$changed(qack_q) |-> qack_q == quiesce_request)
		else $error("quiesce ack moved against request");
	chk_errlog_read: assert property (
		cfg_rd_en && cfg_addr == request_agent_pkg::ERROR_LOG_POINTER_OFS |=>
		cfg_rdata == {20'h00000, ERR_LOG_OFFSET})
		else $error("error log pointer wrong");
	chk_preserved_hold: assert property (
		cfg_wr_en && cfg_addr == request_agent_pkg::AGENT_CONTROL_OFS && cfg_byte_en == 4'hf |=>
		ctrl_q[13:4] == $past(cfg_wdata[13:4]) && ctrl_q[2] == $past(cfg_wdata[2]))
		else $error("preserved bits lost");
	chk_enable_gate: assert property (
		cfg_wr_en && cfg_addr == request_agent_pkg::AGENT_CONTROL_OFS && cfg_byte_en[0] |=>
		request_allowed == $past(cfg_wdata[0]))
		else $error("agent enable not applied");

endmodule

/* verilog/request_agent_pkg.sv */
// Purpose: shared offsets, bit positions and timing for the requesting agent register bank
// Assumes: 20 MHz sys_clk, 32-bit configuration accesses on word offsets
// Notes: the capability status word sits at byte offset 00h of the bank
package request_agent_pkg;

	// register byte offsets
	localparam logic [7:0] CAP_STATUS_OFS = 8'h00;
	localparam logic [7:0] AGENT_CONTROL_OFS = 8'h04;
	localparam logic [7:0] ERROR_LOG_POINTER_OFS = 8'h08;

	// capability status field positions
	localparam int FLUSH_COUNT_LSB = 19;
	localparam int FLUSH_COUNT_MSB = 27;
	localparam int FLUSH_EXP_LSB = 28;
	localparam int FLUSH_EXP_MSB = 30;
	localparam int FLUSH_DONE_BIT = 31;

	// agent control field positions
	localparam int AGENT_ENABLE_BIT = 0;
	localparam int SNOOP_ENABLE_BIT = 1;
	localparam int QUIESCE_REQ_BIT = 3;
	localparam int FLUSH_REQ_BIT = 14;

	// writable bits of agent control: 14, 13:4 (preserved), 3, 2 (preserved), 1, 0
	localparam logic [31:0] CONTROL_WMASK = 32'h0000_7fff;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// time base
	localparam longint CLK_PERIOD_NS = 50;
	localparam longint FLUSH_UNIT_NS = 32;
	localparam int EXP_SHIFT = 5;

	// width of the error log offset field
	localparam int ERR_LOG_W = 12;

	// flush sequencing
	typedef enum logic [1:0]
	{
		FLUSH_IDLE = 2'b00,
		FLUSH_BUSY = 2'b01,
		FLUSH_DONE = 2'b10
	} flush_state_e;

endpackage
